// ### logic/csg_global_config.sv
// global configuration register bank of the clock synthesizer
`timescale 1ns/100ps
// Behaviour
// RULE_01 - doubler powered only while its bit is set
// RULE_02 - software waits 5 ms before doubler enable
// RULE_03 - crystal mode: off, crystal, single-ended input
// RULE_04 - loop enable bit 0, rest read zero
// RULE_05 - input enable bits power inputs three..one
// RULE_06 - output enable bits per output, two registers
// RULE_07 - early revision: one enable per bank
// RULE_08 - group source: integer, fractional/bypass, path two
// RULE_09 - first select holds groups A, B, C
// RULE_10 - second select holds groups D, E, F
// RULE_11 - stop bit stops output when source 0001
// RULE_12 - stop is own bit OR global stop
// RULE_13 - stop bits map outputs onto bit order
// RULE_14 - pin codes: input, inverted, drive low/high
// RULE_15 - pin codes 0100-0111 follow a status bit
// RULE_16 - pin codes 1000-1111 have no function
// RULE_17 - pin status register shows live pin levels
// RULE_18 - first pin config: pin one high nibble
// RULE_19 - status pin bit chosen by own select
// RULE_20 - global stop halts outputs with source 0001
// RULE_21 - unused codes stored, no glitch on clocks; crystal mode 11 powers the crystal pins down
module csg_global_config (
   // clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // processor interface register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // controls held outside this bank
   input wire logic global_output_stop,
   input wire logic [39:0] stop_source_field,
   input wire logic synth_bypass_select,
   input wire logic [15:0] pin_status_select,
   input wire logic [255:0] status_bits,
   // analog block controls
   output csg_pkg::csg_xtal_s xtal_ctrl,
   output logic synth_loop_on,
   output logic [2:0] input_enable,
   output logic [9:0] output_enable_bit,
   output csg_pkg::csg_group_src_s group_source,
   output logic [5:0] group_uses_bypass,
   output logic [9:0] output_stop,
   // general-purpose pins
   input wire logic [1:0] gpio_in,
   output logic [1:0] gpio_out,
   output logic [1:0] gpio_oe,
   output logic [1:0] gpio_value
);
   logic rst_sync1_n;
   logic rst_n;
   logic [7:0] master_config_2;
   logic [7:0] synth_loop_enable;
   logic [7:0] input_clock_enable;
   logic [7:0] output_enable_1;
   logic [7:0] output_enable_2;
   logic [7:0] output_source_select_1;
   logic [7:0] output_source_select_2;
   logic [7:0] output_halt_control_1;
   logic [7:0] output_halt_control_2;
   logic [7:0] gpio_config_1;
   logic [7:0] next_rdata;
   logic [11:0] raw_source;
   logic [11:0] applied_source;
   logic [9:0] stop_bits;
   logic [9:0] next_stop;
   logic [1:0] pin_status_bit;
   logic [1:0] pin_level;
   csg_pkg::csg_pin_s pin_q [2];

   // reset release through two flops
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync1_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync1_n <= 1'b1;
         rst_n <= rst_sync1_n;
      end
   end

   // register writes, reserved bits stay zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         master_config_2 <= csg_pkg::REG_RESET;
         synth_loop_enable <= csg_pkg::REG_RESET;
         input_clock_enable <= csg_pkg::REG_RESET;
         output_enable_1 <= csg_pkg::REG_RESET;
         output_enable_2 <= csg_pkg::REG_RESET;
         output_source_select_1 <= csg_pkg::REG_RESET;
         output_source_select_2 <= csg_pkg::REG_RESET;
         output_halt_control_1 <= csg_pkg::REG_RESET;
         output_halt_control_2 <= csg_pkg::REG_RESET;
         gpio_config_1 <= csg_pkg::REG_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            csg_pkg::ADDR_MASTER_CONFIG_2:
               master_config_2 <= reg_wdata & csg_pkg::MASK_MASTER_CONFIG_2;
            csg_pkg::ADDR_SYNTH_LOOP_ENABLE: // RULE_04
               synth_loop_enable <=
                  reg_wdata & csg_pkg::MASK_SYNTH_LOOP_ENABLE;
            csg_pkg::ADDR_INPUT_CLOCK_ENABLE: // RULE_05
               input_clock_enable <=
                  reg_wdata & csg_pkg::MASK_INPUT_CLOCK_ENABLE;
            csg_pkg::ADDR_OUTPUT_ENABLE_1: // RULE_06
               output_enable_1 <= reg_wdata;
            csg_pkg::ADDR_OUTPUT_ENABLE_2: // RULE_06
               output_enable_2 <= reg_wdata & csg_pkg::MASK_OUTPUT_ENABLE_2;
            csg_pkg::ADDR_OUTPUT_SOURCE_SELECT_1: // RULE_09 RULE_21
               output_source_select_1 <=
                  reg_wdata & csg_pkg::MASK_SOURCE_SELECT;
            csg_pkg::ADDR_OUTPUT_SOURCE_SELECT_2: // RULE_10 RULE_21
               output_source_select_2 <=
                  reg_wdata & csg_pkg::MASK_SOURCE_SELECT;
            csg_pkg::ADDR_OUTPUT_HALT_CONTROL_1: // RULE_13
               output_halt_control_1 <= reg_wdata;
            csg_pkg::ADDR_OUTPUT_HALT_CONTROL_2: // RULE_13
               output_halt_control_2 <=
                  reg_wdata & csg_pkg::MASK_HALT_CONTROL_2;
            csg_pkg::ADDR_GPIO_CONFIG_1: // RULE_18 RULE_21
               gpio_config_1 <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      case (reg_addr)
         csg_pkg::ADDR_MASTER_CONFIG_2: next_rdata = master_config_2;
         csg_pkg::ADDR_SYNTH_LOOP_ENABLE: next_rdata = synth_loop_enable;
         csg_pkg::ADDR_INPUT_CLOCK_ENABLE: next_rdata = input_clock_enable;
         csg_pkg::ADDR_OUTPUT_ENABLE_1: next_rdata = output_enable_1;
         csg_pkg::ADDR_OUTPUT_ENABLE_2: next_rdata = output_enable_2;
         csg_pkg::ADDR_OUTPUT_SOURCE_SELECT_1:
            next_rdata = output_source_select_1;
         csg_pkg::ADDR_OUTPUT_SOURCE_SELECT_2:
            next_rdata = output_source_select_2;
         csg_pkg::ADDR_OUTPUT_HALT_CONTROL_1:
            next_rdata = output_halt_control_1;
         csg_pkg::ADDR_OUTPUT_HALT_CONTROL_2:
            next_rdata = output_halt_control_2;
         csg_pkg::ADDR_GPIO_CONFIG_1: next_rdata = gpio_config_1;
         csg_pkg::ADDR_PIN_STATUS_REGISTER:
            next_rdata = {6'h00, pin_level}; // RULE_17
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // crystal pins, doubler, loop and input receivers
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         xtal_ctrl <= '0;
         synth_loop_on <= 1'b0;
         input_enable <= 3'h0;
         output_enable_bit <= 10'h000;
      end else begin
         xtal_ctrl.doubler_on <=
            master_config_2[csg_pkg::DOUBLER_BIT]; // RULE_01
         // mode 11 is treated as powered down
         case (master_config_2[1:0])
            csg_pkg::XTAL_CRYSTAL: begin
               xtal_ctrl.driver_on <= 1'b1; // RULE_03
               xtal_ctrl.input_on <= 1'b1;
               xtal_ctrl.single_ended <= 1'b0;
            end
            csg_pkg::XTAL_SINGLE: begin
               xtal_ctrl.driver_on <= 1'b0; // RULE_03
               xtal_ctrl.input_on <= 1'b1;
               xtal_ctrl.single_ended <= 1'b1;
            end
            default: begin
               xtal_ctrl.driver_on <= 1'b0; // RULE_03 RULE_21
               xtal_ctrl.input_on <= 1'b0;
               xtal_ctrl.single_ended <= 1'b0;
            end
         endcase
         synth_loop_on <= synth_loop_enable[0]; // RULE_04
         input_enable <= input_clock_enable[2:0]; // RULE_05
         output_enable_bit <=
            {output_enable_2[1:0], output_enable_1}; // RULE_06
      end
   end

   // group sources: an unused code keeps the previous path selected
   assign raw_source = {output_source_select_2[5:0],
                        output_source_select_1[5:0]}; // RULE_09 RULE_10

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         applied_source <= 12'h000;
         group_uses_bypass <= 6'h00;
      end else begin
         for (int g = 0; g < 6; g++) begin
            if (raw_source[2*g +: 2] != csg_pkg::SRC_UNUSED) begin
               applied_source[2*g +: 2] <=
                  raw_source[2*g +: 2]; // RULE_08 RULE_21
            end
            group_uses_bypass[g] <= synth_bypass_select &&
               (applied_source[2*g +: 2] == csg_pkg::SRC_FRACTIONAL); // RULE_08
         end
      end
   end

   assign group_source = csg_pkg::csg_group_src_s'(applied_source);

   // per-output stop: own bit or global bit, gated by stop source
   assign stop_bits = {output_halt_control_2[1:0],
                       output_halt_control_1}; // RULE_13

   always_comb begin
      for (int k = 0; k < 10; k++) begin
         next_stop[k] = (stop_bits[k] | global_output_stop) && // RULE_12
            (stop_source_field[4*k +: 4] ==
             csg_pkg::STOP_SRC_REGISTER); // RULE_11 RULE_20
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         output_stop <= 10'h000;
      end else begin
         output_stop <= next_stop;
      end
   end

   // general-purpose pins
   for (genvar p = 0; p < 2; p++) begin : g_pin
      logic [4:0] sel_reg;
      logic [7:0] sel_index;
      logic [3:0] pin_cfg;
      assign sel_reg = pin_status_select[8*p+3 +: 5];
      assign sel_index = pin_status_select[8*p +: 8];
      assign pin_cfg =
         gpio_config_1[csg_pkg::PIN_ONE_CONFIG_LSB*p +: 4]; // RULE_18
      // the pin status register itself cannot be followed
      assign pin_status_bit[p] = (sel_reg == csg_pkg::PIN_STATUS_REG_NUM) ?
         1'b0 : status_bits[sel_index]; // RULE_19
      csg_gpio_pin u_pin (
         .clk(sys_clk),
         .rst_n(rst_n),
         .pin_config(pin_cfg),
         .status_bit(pin_status_bit[p]),
         .pin_in(gpio_in[p]),
         .pin(pin_q[p])
      );
      assign gpio_out[p] = pin_q[p].pin_out;
      assign gpio_oe[p] = pin_q[p].pin_oe;
      assign gpio_value[p] = pin_q[p].pin_value;
   end

   // live pin level, whatever the configuration
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_level <= 2'h0;
      end else begin
         pin_level <= gpio_in; // RULE_17
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_DOUBLER: assert property ( // RULE_01
      reg_wr && reg_addr == csg_pkg::ADDR_MASTER_CONFIG_2
      |=> ##1 xtal_ctrl.doubler_on == $past(reg_wdata[2], 2))
      else $error("doubler enable does not follow its bit");
   AST_XTAL_MODE: assert property ( // RULE_03
      master_config_2[1:0] == csg_pkg::XTAL_OFF ##1
      master_config_2[1:0] == csg_pkg::XTAL_OFF
      |-> !xtal_ctrl.driver_on && !xtal_ctrl.input_on)
      else $error("crystal pins powered in off mode");
   AST_LOOP_READ: assert property ( // RULE_04
      reg_rd && reg_addr == csg_pkg::ADDR_SYNTH_LOOP_ENABLE
      |=> reg_rdata[7:1] == 7'h00 &&
      reg_rdata[0] == $past(synth_loop_enable[0]))
      else $error("loop enable register reads wrong");
   AST_OUT_ENABLE: assert property ( // RULE_06
      reg_wr && reg_addr == csg_pkg::ADDR_OUTPUT_ENABLE_2 ##1 !reg_wr
      |=> output_enable_bit[9:8] == $past(reg_wdata[1:0], 2))
      else $error("outputs nine and ten enable wrong");
   AST_SRC_HOLD: assert property ( // RULE_08
      raw_source[1:0] == csg_pkg::SRC_UNUSED |=> $stable(applied_source[1:0]))
      else $error("unused source code changed the path");
   AST_SRC_APPLY: assert property ( // RULE_09
      raw_source[5:4] != csg_pkg::SRC_UNUSED
      |=> group_source.group_c_source == $past(raw_source[5:4]))
      else $error("group C source not applied");
   AST_GLOBAL_STOP: assert property ( // RULE_20
      global_output_stop && stop_source_field[3:0] == csg_pkg::STOP_SRC_REGISTER
      |=> output_stop[0])
      else $error("global stop did not halt output one");
   AST_STOP_GATE: assert property ( // RULE_11
      stop_source_field[39:36] != csg_pkg::STOP_SRC_REGISTER
      |=> !output_stop[9])
      else $error("output ten stopped with other stop source");
   AST_PIN_DRIVE: assert property ( // RULE_14
      gpio_config_1[3:0] == 4'h3 ##1 gpio_config_1[3:0] == 4'h3
      |-> gpio_oe[0] && gpio_out[0])
      else $error("pin zero not driving high");
   AST_PIN_STATUS: assert property ( // RULE_17
      reg_rd && reg_addr == csg_pkg::ADDR_PIN_STATUS_REGISTER
      |=> reg_rdata[1:0] == $past(pin_level))
      else $error("pin status register not live");
   AST_INPUT_EN: assert property ( // RULE_05
      reg_wr && reg_addr == csg_pkg::ADDR_INPUT_CLOCK_ENABLE ##1 !reg_wr
      |=> input_enable == $past(reg_wdata[2:0], 2))
      else $error("input enables do not follow their bits");
   AST_SRC_GROUP_F: assert property ( // RULE_10
      output_source_select_2[5:4] != csg_pkg::SRC_UNUSED
      |=> group_source.group_f_source == $past(output_source_select_2[5:4]))
      else $error("group F source not applied");
   AST_STOP_MAP: assert property ( // RULE_13
      output_halt_control_2[0] &&
      stop_source_field[35:32] == csg_pkg::STOP_SRC_REGISTER
      |=> output_stop[8])
      else $error("stop bit of output nine not mapped");
   AST_STOP_OWN: assert property ( // RULE_12
      !global_output_stop &&
      stop_source_field[27:24] == csg_pkg::STOP_SRC_REGISTER
      |=> output_stop[6] == $past(output_halt_control_1[6]))
      else $error("own stop bit of output seven ignored");
   AST_STAT_PIN: assert property ( // RULE_15
      gpio_config_1[7:4] == 4'h4 ##1 gpio_config_1[7:4] == 4'h4
      |-> gpio_oe[1] && gpio_out[1] == $past(pin_status_bit[1]))
      else $error("pin one does not follow its status bit");
   AST_INV_INPUT: assert property ( // RULE_14
      gpio_config_1[3:0] == 4'h1 |=> gpio_value[0] == !$past(gpio_in[0]))
      else $error("inverted input not inverted");
   AST_UNUSED_PIN: assert property ( // RULE_16
      gpio_config_1[3] |=> !gpio_oe[0])
      else $error("unused pin code drives the pin");

   COV_DOUBLER_ON: cover property (xtal_ctrl.doubler_on && xtal_ctrl.driver_on);
   COV_BYPASS: cover property (group_uses_bypass[0]);
   COV_STOPPED: cover property (output_stop[4]);
   COV_STATUS_PIN: cover property (gpio_oe[1] && gpio_config_1[7:4] == 4'h7);
   COV_SRC_HELD: cover property (raw_source[1:0] == csg_pkg::SRC_UNUSED);
endmodule

// ### logic/csg_gpio_pin.sv
// one general-purpose pin: configuration decode and registered drive
`timescale 1ns/100ps
module csg_gpio_pin (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration and sources
   input wire logic [3:0] pin_config,
   input wire logic status_bit,
   input wire logic pin_in,
   // pin drive and sampled value
   output csg_pkg::csg_pin_s pin
);
   csg_pkg::csg_pin_s next_pin;

   always_comb begin
      next_pin.pin_out = 1'b0;
      next_pin.pin_oe = 1'b0;
      next_pin.pin_value = pin_in;
      case (csg_pkg::csg_pin_mode_e'(pin_config))
         csg_pkg::CSG_PIN_IN: next_pin.pin_value = pin_in; // RULE_14
         csg_pkg::CSG_PIN_IN_INV: next_pin.pin_value = ~pin_in; // RULE_14
         csg_pkg::CSG_PIN_OUT_LOW: next_pin.pin_oe = 1'b1; // RULE_14
         csg_pkg::CSG_PIN_OUT_HIGH: begin
            next_pin.pin_oe = 1'b1; // RULE_14
            next_pin.pin_out = 1'b1;
         end
         csg_pkg::CSG_PIN_STAT: begin
            next_pin.pin_oe = 1'b1; // RULE_15
            next_pin.pin_out = status_bit;
         end
         csg_pkg::CSG_PIN_STAT_INV: begin
            next_pin.pin_oe = 1'b1; // RULE_15
            next_pin.pin_out = ~status_bit;
         end
         csg_pkg::CSG_PIN_STAT_LOW0: next_pin.pin_oe = ~status_bit; // RULE_15
         csg_pkg::CSG_PIN_STAT_LOW1: next_pin.pin_oe = status_bit; // RULE_15
         // unused codes leave the pin undriven, as an input
         default: next_pin.pin_oe = 1'b0; // RULE_16 RULE_21
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin <= '0;
      end else begin
         pin <= next_pin;
      end
   end
endmodule

// ### logic/csg_pkg.sv
// shared constants and carrier types for the global configuration bank
package csg_pkg;
   // register offsets
   localparam logic [7:0] ADDR_MASTER_CONFIG_2 = 8'h02;
   localparam logic [7:0] ADDR_SYNTH_LOOP_ENABLE = 8'h03;
   localparam logic [7:0] ADDR_INPUT_CLOCK_ENABLE = 8'h04;
   localparam logic [7:0] ADDR_OUTPUT_ENABLE_1 = 8'h05;
   localparam logic [7:0] ADDR_OUTPUT_ENABLE_2 = 8'h06;
   localparam logic [7:0] ADDR_OUTPUT_SOURCE_SELECT_1 = 8'h07;
   localparam logic [7:0] ADDR_OUTPUT_SOURCE_SELECT_2 = 8'h08;
   localparam logic [7:0] ADDR_OUTPUT_HALT_CONTROL_1 = 8'h09;
   localparam logic [7:0] ADDR_OUTPUT_HALT_CONTROL_2 = 8'h0A;
   localparam logic [7:0] ADDR_GPIO_CONFIG_1 = 8'h0B;
   localparam logic [7:0] ADDR_PIN_STATUS_REGISTER = 8'h41;
   // reset value and writable bit masks
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] MASK_MASTER_CONFIG_2 = 8'hF7;
   localparam logic [7:0] MASK_SYNTH_LOOP_ENABLE = 8'h01;
   localparam logic [7:0] MASK_INPUT_CLOCK_ENABLE = 8'h07;
   localparam logic [7:0] MASK_OUTPUT_ENABLE_2 = 8'h03;
   localparam logic [7:0] MASK_SOURCE_SELECT = 8'h3F;
   localparam logic [7:0] MASK_HALT_CONTROL_2 = 8'h03;
   // field positions
   localparam int DOUBLER_BIT = 2;
   localparam int PIN_ONE_CONFIG_LSB = 4;
   // status register number that a pin may not follow
   localparam logic [4:0] PIN_STATUS_REG_NUM = 5'h01;
   // crystal pin mode codes
   localparam logic [1:0] XTAL_OFF = 2'h0;
   localparam logic [1:0] XTAL_CRYSTAL = 2'h1;
   localparam logic [1:0] XTAL_SINGLE = 2'h2;
   // output group source codes
   localparam logic [1:0] SRC_INTEGER = 2'h0;
   localparam logic [1:0] SRC_FRACTIONAL = 2'h1;
   localparam logic [1:0] SRC_UNUSED = 2'h2;
   localparam logic [1:0] SRC_PATH_TWO = 2'h3;
   // stop source code that lets the stop bits act
   localparam logic [3:0] STOP_SRC_REGISTER = 4'h1;

   typedef enum logic [3:0] {
      CSG_PIN_IN = 4'h0,
      CSG_PIN_IN_INV = 4'h1,
      CSG_PIN_OUT_LOW = 4'h2,
      CSG_PIN_OUT_HIGH = 4'h3,
      CSG_PIN_STAT = 4'h4,
      CSG_PIN_STAT_INV = 4'h5,
      CSG_PIN_STAT_LOW0 = 4'h6,
      CSG_PIN_STAT_LOW1 = 4'h7
   } csg_pin_mode_e;

   typedef struct packed {
      logic driver_on;
      logic input_on;
      logic single_ended;
      logic doubler_on;
   } csg_xtal_s;

   typedef struct packed {
      logic [1:0] group_f_source;
      logic [1:0] group_e_source;
      logic [1:0] group_d_source;
      logic [1:0] group_c_source;
      logic [1:0] group_b_source;
      logic [1:0] group_a_source;
   } csg_group_src_s;

   typedef struct packed {
      logic pin_out;
      logic pin_oe;
      logic pin_value;
   } csg_pin_s;
endpackage

// ### tb/csg_global_config_tb.sv
// self-checking bench for the global configuration register bank
`timescale 1ns/100ps
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin \
   error_cnt++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module csg_global_config_tb;
   localparam logic [7:0] MA [12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
      8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h01, 8'h0C};
   localparam logic [7:0] MK [12] = '{8'hF7, 8'h01, 8'h07, 8'hFF, 8'h03,
      8'h3F, 8'h3F, 8'hFF, 8'h03, 8'hFF, 8'h00, 8'h00};
   int error_cnt = 0;
   int checked = 0;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic global_output_stop = 1'b0;
   logic [39:0] stop_source_field = 40'h0;
   logic synth_bypass_select = 1'b0;
   logic [15:0] pin_status_select = 16'h221D;
   logic [255:0] status_bits = '0;
   csg_pkg::csg_xtal_s xtal_ctrl;
   logic synth_loop_on;
   logic [2:0] input_enable;
   logic [9:0] output_enable_bit;
   csg_pkg::csg_group_src_s group_source;
   logic [5:0] group_uses_bypass;
   logic [9:0] output_stop;
   logic [1:0] gpio_in = 2'h1;
   logic [1:0] gpio_out;
   logic [1:0] gpio_oe;
   logic [1:0] gpio_value;

   always #2.5 sys_clk = ~sys_clk;

   csg_global_config u_csg_global_config (
      .sys_clk(sys_clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .global_output_stop(global_output_stop),
      .stop_source_field(stop_source_field),
      .synth_bypass_select(synth_bypass_select),
      .pin_status_select(pin_status_select), .status_bits(status_bits),
      .xtal_ctrl(xtal_ctrl), .synth_loop_on(synth_loop_on),
      .input_enable(input_enable), .output_enable_bit(output_enable_bit),
      .group_source(group_source), .group_uses_bypass(group_uses_bypass),
      .output_stop(output_stop), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe(gpio_oe), .gpio_value(gpio_value)
   );

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic do_reset();
      arst_n = 1'b0;
      tick(3);
      arst_n = 1'b1;
      tick(3);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                         input string m);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      tick(1);
      `CHK(reg_rdata, e, m)
   endtask

   task automatic test_reset_values();
      for (int i = 0; i < 12; i++) begin
         rd_chk(MA[i], 8'h00, "reset value");
      end
      `CHK(output_enable_bit, 10'h000, "enables after reset")
      `CHK(output_stop, 10'h000, "stops after reset")
   endtask

   task automatic test_masks();
      for (int i = 0; i < 12; i++) begin
         wr(MA[i], 8'hFF);
         rd_chk(MA[i], MK[i], "writable bits");
      end
      `CHK(synth_loop_on, 1'b1, "loop on")
      `CHK(input_enable, 3'h7, "inputs on")
      `CHK(output_enable_bit, 10'h3FF, "outputs on")
      for (int i = 0; i < 12; i++) begin
         wr(MA[i], 8'h00);
      end
   endtask

   task automatic test_xtal();
      logic [1:0] md;
      logic [3:0] ex;
      for (int i = 0; i < 8; i++) begin
         md = i[1:0];
         ex = {md == 2'h1, md == 2'h1 || md == 2'h2, md == 2'h2, i[2]};
         // crystal mode settles before the doubler bit is raised
         wr(8'h02, {6'h00, md});
         wr(8'h02, {5'h00, i[2:0]});
         tick(2);
         `CHK(xtal_ctrl, ex, "crystal controls")
      end
      wr(8'h02, 8'h00);
   endtask

   task automatic test_enables();
      wr(8'h03, 8'h01);
      wr(8'h04, 8'h05);
      wr(8'h05, 8'h81);
      wr(8'h06, 8'h02);
      tick(2);
      `CHK(synth_loop_on, 1'b1, "loop enable")
      `CHK(input_enable, 3'h5, "input enables")
      `CHK(output_enable_bit, 10'h281, "output enables")
      wr(8'h03, 8'hFE);
      tick(2);
      `CHK(synth_loop_on, 1'b0, "loop disable")
      rd_chk(8'h03, 8'h00, "loop upper bits");
   endtask

   task automatic test_groups();
      synth_bypass_select = 1'b1;
      wr(8'h07, 8'h07);
      wr(8'h08, 8'h0D);
      tick(2);
      `CHK(group_source, 12'h347, "group sources")
      `CHK(group_uses_bypass, 6'h0A, "bypass groups")
      synth_bypass_select = 1'b0;
      wr(8'h07, 8'h06);
      tick(2);
      `CHK(group_uses_bypass, 6'h00, "fractional groups")
      `CHK(group_source, 12'h347, "unused code held")
      rd_chk(8'h07, 8'h06, "unused code stored");
   endtask

   task automatic test_stops();
      logic [9:0] t [6];
      t = '{{8'hFF, 2'h3}, {8'h00, 2'h0}, {8'h00, 2'h0},
            {8'h04, 2'h1}, {8'h02, 2'h2}, {8'h01, 2'h0}};
      for (int k = 0; k < 10; k++) begin
         stop_source_field[4*k +: 4] = k[0] ? 4'h2 : 4'h1;
      end
      for (int i = 0; i < 6; i++) begin
         global_output_stop = (i == 1);
         wr(8'h09, t[i][9:2]);
         wr(8'h0A, {6'h00, t[i][1:0]});
         tick(2);
         case (i)
            0, 1: `CHK(output_stop, 10'h155, "stop set")
            3: `CHK(output_stop, 10'h104, "stop mapping")
            5: `CHK(output_stop, 10'h001, "first stop bit")
            default: `CHK(output_stop, 10'h000, "no stop")
         endcase
      end
   endtask

   task automatic pin_chk(input int i, input logic [3:0] c, input logic s);
      logic oe_e;
      logic out_e;
      oe_e = !c[3] && (c[2] ? (!c[1] || (s ^ !c[0])) : c[1]);
      out_e = c[2] ? (!c[1] && (s ^ c[0])) : c[0];
      `CHK(gpio_oe[i], oe_e, "pin drive enable")
      if (oe_e) `CHK(gpio_out[i], out_e, "pin level")
      if (c[3] || c[3:1] == 3'h0)
         `CHK(gpio_value[i], gpio_in[i] ^ (c == 4'h1), "pin input")
   endtask

   task automatic test_pins();
      logic [3:0] c;
      for (int i = 0; i < 32; i++) begin
         c = i[4:1];
         status_bits = i[0] ? '0 : '1;
         status_bits[29] = i[0];
         status_bits[34] = i[0];
         wr(8'h0B, {c ^ 4'h2, c});
         tick(2);
         pin_chk(0, c, i[0]);
         pin_chk(1, c ^ 4'h2, i[0]);
      end
      wr(8'h0B, 8'h32);
      gpio_in = 2'h2;
      tick(2);
      rd_chk(8'h41, 8'h02, "pin status");
      gpio_in = 2'h1;
      tick(2);
      rd_chk(8'h41, 8'h01, "pin status");
      // pin zero points at the pin status register and must drive low
      pin_status_select = 16'h220D;
      status_bits = '1;
      wr(8'h0B, 8'h44);
      tick(2);
      `CHK(gpio_out, 2'h2, "status register not followed")
      `CHK(gpio_oe, 2'h3, "status pins driven")
   endtask

   task automatic test_reset_again();
      wr(8'h03, 8'h01);
      do_reset();
      `CHK(synth_loop_on, 1'b0, "loop after reset")
      rd_chk(8'h03, 8'h00, "register after reset");
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      test_done();
   end

   initial begin
      do_reset();
      test_reset_values();
      test_masks();
      test_xtal();
      test_enables();
      test_groups();
      test_stops();
      test_pins();
      test_reset_again();
      test_done();
   end
endmodule
